// ==== verilog/isoch_rx_header_check.sv ====
// Purpose: Configuration and header checking of one isochronous receive channel
// Assumes: Link receive path on the same clock, one header beat then data beats
// Notes:   Registers over classic Wishbone; one level interrupt output
//
// Summary of operation
// (R1) With FN check on, differing incoming FN raises configuration fail.
// (R2) With QPS check on, differing incoming QPS raises configuration fail.
// (R3) With SPH check on, differing incoming SPH raises configuration fail.
// (R4) With TAG check on, differing packet TAG raises configuration fail.
// (R5) Interval doubling counts data blocks at twice the announced size.
// (R6) Software must force size and FDF for interval 16 before doubling.
// (R7) Empty packets are found by FDF when selected, else by FMT.
// (R8) Forced SPH replaces the SPH carried in received CIP headers.
// (R9) Forced TAG replaces the TAG carried in isochronous packet headers.
// (R10) With source check on, differing source ID raises source ID fail.
// (R11) The reserved configuration bits 30 and 8 always read as zero.
// (R12) The partition field selects which Media FIFO partition is written.
// (R13) Only packets on the programmed channel number are taken.
// (R14) Nothing is processed while the receive enable bit is clear.
// (R15) FMT, FDF and DBS checks likewise raise configuration fail.
// (R16) Mismatch indications stay sticky until software clears them.
// (R17) Header checks finish once per packet before its data is written.
module isoch_rx_header_check (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [ihc_pkg::ADDR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Received header
  input wire logic HDR_VALID_IN,
  output logic HDR_READY_OUT,
  input wire logic [5:0] HDR_CHAN_IN,
  input wire logic [1:0] HDR_TAG_IN,
  input wire logic [5:0] HDR_SID_IN,
  input wire logic [1:0] HDR_FN_IN,
  input wire logic [2:0] HDR_QPS_IN,
  input wire logic HDR_SPH_IN,
  input wire logic [5:0] HDR_FMT_IN,
  input wire logic [7:0] HDR_FDF_IN,
  input wire logic [7:0] HDR_DBS_IN,
  // Received data quadlets
  input wire logic DQ_VALID_IN,
  output logic DQ_READY_OUT,
  input wire logic [31:0] DQ_DATA_IN,
  input wire logic DQ_LAST_IN,
  // Media FIFO write side
  output logic MF_WR_OUT,
  output logic [31:0] MF_DATA_OUT,
  output logic [1:0] MF_PART_OUT,
  output logic MF_BLK_END_OUT,
  // Stream attributes towards the router
  output logic RX_SPH_OUT,
  output logic [1:0] RX_TAG_OUT,
  output logic [8:0] RX_DB_SIZE_OUT,
  // Interrupt
  output logic IRQ_OUT
);

  ihc_chk_if chk_if ();

  logic [31:0] cfg_reg, cfg_next;
  logic [31:0] loc_reg, loc_next;
  logic [ihc_pkg::STAT_W-1:0] stat_reg, stat_next;
  logic [ihc_pkg::STAT_W-1:0] ien_reg, ien_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic irq_reg, irq_next;
  ihc_pkg::ihc_state_t state_reg, state_next;
  logic [8:0] db_size_reg, db_size_next;
  logic [8:0] db_cnt_reg, db_cnt_next;
  logic mf_wr_reg, mf_wr_next;
  logic [31:0] mf_data_reg, mf_data_next;
  logic [1:0] mf_part_reg, mf_part_next;
  logic mf_end_reg, mf_end_next;
  logic sph_reg, sph_next;
  logic [1:0] tag_reg, tag_next;
  logic bus_req;
  logic hdr_take;

  // ----------------------------------------------------------------
  // Header checker
  // ----------------------------------------------------------------
  assign hdr_take = HDR_VALID_IN && (state_reg == ihc_pkg::IHC_IDLE);
  assign chk_if.cfg = cfg_reg;
  assign chk_if.loc = loc_reg;
  assign chk_if.hdr_stb = hdr_take && cfg_reg[ihc_pkg::BIT_ENABLE] &&
                          (HDR_CHAN_IN == cfg_reg[ihc_pkg::CHAN_LSB +: 6]); // R13 R14
  assign chk_if.hdr_tag = HDR_TAG_IN;
  assign chk_if.hdr_sid = HDR_SID_IN;
  assign chk_if.hdr_fn = HDR_FN_IN;
  assign chk_if.hdr_qps = HDR_QPS_IN;
  assign chk_if.hdr_sph = HDR_SPH_IN;
  assign chk_if.hdr_fmt = HDR_FMT_IN;
  assign chk_if.hdr_fdf = HDR_FDF_IN;
  assign chk_if.hdr_dbs = HDR_DBS_IN;

  ihc_hdr_check u_check (
    .clk_in(CLK_SYS_IN),
    .resetn_in(RESETN_IN),
    .chk(chk_if.chk)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign bus_req = WB_CYC_IN && WB_STB_IN && !ack_reg;

  always_comb begin
    logic [31:0] bmask;
    logic [ihc_pkg::STAT_W-1:0] ev;
    logic [ihc_pkg::STAT_W-1:0] clr;
    bmask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
    ev = '0;
    clr = '0;
    cfg_next = cfg_reg;
    loc_next = loc_reg;
    ien_next = ien_reg;
    ack_next = bus_req;
    rdat_next = rdat_reg;
    if (bus_req && WB_WE_IN) begin
      unique case (WB_ADR_IN)
        ihc_pkg::CFG_OFS:
          cfg_next = (cfg_reg & ~(bmask & ihc_pkg::CFG_WMASK)) |
                     (WB_DAT_IN & bmask & ihc_pkg::CFG_WMASK); // R11
        ihc_pkg::LOC_OFS:
          loc_next = (loc_reg & ~(bmask & ihc_pkg::LOC_WMASK)) |
                     (WB_DAT_IN & bmask & ihc_pkg::LOC_WMASK);
        ihc_pkg::CLR_OFS:
          clr = WB_DAT_IN[ihc_pkg::STAT_W-1:0] & bmask[ihc_pkg::STAT_W-1:0];
        ihc_pkg::IEN_OFS:
          ien_next = (ien_reg & ~bmask[ihc_pkg::STAT_W-1:0]) |
                     (WB_DAT_IN[ihc_pkg::STAT_W-1:0] & bmask[ihc_pkg::STAT_W-1:0]);
        default: ;
      endcase
    end
    if (bus_req && !WB_WE_IN) begin
      unique case (WB_ADR_IN)
        ihc_pkg::CFG_OFS: rdat_next = cfg_reg & ihc_pkg::CFG_WMASK; // R11
        ihc_pkg::LOC_OFS: rdat_next = loc_reg & ihc_pkg::LOC_WMASK;
        ihc_pkg::STAT_OFS: rdat_next = {{(32-ihc_pkg::STAT_W){1'b0}}, stat_reg};
        ihc_pkg::IEN_OFS: rdat_next = {{(32-ihc_pkg::STAT_W){1'b0}}, ien_reg};
        default: rdat_next = 32'h0000_0000;
      endcase
    end
    if (chk_if.done) begin
      ev[ihc_pkg::ST_CFG_FAIL] = chk_if.cfg_fail; // R1 R2 R3 R4 R15
      ev[ihc_pkg::ST_SID_FAIL] = chk_if.sid_fail; // R10
      ev[ihc_pkg::ST_NODATA] = chk_if.nodata;
    end
    stat_next = (stat_reg & ~clr) | ev; // R16
    irq_next = |(stat_next & ien_next);
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cfg_reg <= ihc_pkg::CFG_RST;
      loc_reg <= ihc_pkg::LOC_RST;
      stat_reg <= ihc_pkg::STAT_RST;
      ien_reg <= ihc_pkg::STAT_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      loc_reg <= loc_next;
      stat_reg <= stat_next;
      ien_reg <= ien_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Packet sequencing and data block counting
  // ----------------------------------------------------------------
  always_comb begin
    logic blk_end;
    blk_end = 1'b0;
    state_next = state_reg;
    db_size_next = db_size_reg;
    db_cnt_next = db_cnt_reg;
    mf_wr_next = 1'b0;
    mf_data_next = mf_data_reg;
    mf_part_next = mf_part_reg;
    mf_end_next = 1'b0;
    sph_next = sph_reg;
    tag_next = tag_reg;
    unique case (state_reg)
      ihc_pkg::IHC_IDLE: begin
        if (HDR_VALID_IN) begin
          if (chk_if.hdr_stb) begin
            state_next = ihc_pkg::IHC_CHECK; // R17
            if (cfg_reg[ihc_pkg::BIT_SYT_DBL]) begin
              db_size_next = {HDR_DBS_IN, 1'b0}; // R5
            end else begin
              db_size_next = {1'b0, HDR_DBS_IN};
            end
          end else begin
            state_next = ihc_pkg::IHC_SKIP; // R13 R14
          end
        end
      end
      ihc_pkg::IHC_CHECK: begin
        sph_next = chk_if.eff_sph; // R8
        tag_next = chk_if.eff_tag; // R9
        mf_part_next = cfg_reg[ihc_pkg::PART_LSB +: 2]; // R12
        db_cnt_next = 9'h000;
        state_next = chk_if.nodata ? ihc_pkg::IHC_SKIP : ihc_pkg::IHC_DATA; // R7 R17
      end
      ihc_pkg::IHC_DATA: begin
        if (DQ_VALID_IN) begin
          blk_end = (db_size_reg != 9'h000) && (db_cnt_reg == db_size_reg - 9'h001); // R5
          mf_wr_next = 1'b1;
          mf_data_next = DQ_DATA_IN;
          mf_end_next = blk_end;
          db_cnt_next = blk_end ? 9'h000 : db_cnt_reg + 9'h001;
          if (DQ_LAST_IN) begin
            state_next = ihc_pkg::IHC_IDLE;
          end
        end
      end
      ihc_pkg::IHC_SKIP: begin
        if (DQ_VALID_IN && DQ_LAST_IN) begin
          state_next = ihc_pkg::IHC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_reg <= ihc_pkg::IHC_IDLE;
      db_size_reg <= 9'h000;
      db_cnt_reg <= 9'h000;
      mf_wr_reg <= 1'b0;
      mf_data_reg <= 32'h0000_0000;
      mf_part_reg <= 2'h0;
      mf_end_reg <= 1'b0;
      sph_reg <= 1'b0;
      tag_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      db_size_reg <= db_size_next;
      db_cnt_reg <= db_cnt_next;
      mf_wr_reg <= mf_wr_next;
      mf_data_reg <= mf_data_next;
      mf_part_reg <= mf_part_next;
      mf_end_reg <= mf_end_next;
      sph_reg <= sph_next;
      tag_reg <= tag_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HDR_READY_OUT = (state_reg == ihc_pkg::IHC_IDLE);
  assign DQ_READY_OUT = (state_reg == ihc_pkg::IHC_DATA) || (state_reg == ihc_pkg::IHC_SKIP);
  assign WB_ACK_OUT = ack_reg;
  assign WB_DAT_OUT = rdat_reg;
  assign MF_WR_OUT = mf_wr_reg;
  assign MF_DATA_OUT = mf_data_reg;
  assign MF_PART_OUT = mf_part_reg;
  assign MF_BLK_END_OUT = mf_end_reg;
  assign RX_SPH_OUT = sph_reg;
  assign RX_TAG_OUT = tag_reg;
  assign RX_DB_SIZE_OUT = db_size_reg;
  assign IRQ_OUT = irq_reg;

endmodule

// ==== verilog/ihc_pkg.sv ====
// Purpose: Shared constants for the isochronous receive header checker
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   Offsets are byte addresses, one aligned word per register
package ihc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] CFG_OFS = 5'h00;
  localparam logic [4:0] LOC_OFS = 5'h04;
  localparam logic [4:0] STAT_OFS = 5'h08;
  localparam logic [4:0] CLR_OFS = 5'h0c;
  localparam logic [4:0] IEN_OFS = 5'h10;

  // ----------------------------------------------------------------
  // Stream configuration register fields
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 31;
  localparam int BIT_FMT_CHK = 29;
  localparam int BIT_FDF_CHK = 28;
  localparam int BIT_DBS_CHK = 27;
  localparam int BIT_FN_CHK = 26;
  localparam int BIT_QPS_CHK = 25;
  localparam int BIT_SPH_CHK = 24;
  localparam int BIT_TAG_CHK = 23;
  localparam int BIT_SYT_DBL = 22;
  localparam int BIT_NODATA_FDF = 21;
  localparam int BIT_SPH_FORCE = 20;
  localparam int BIT_SPH_VAL = 19;
  localparam int BIT_TAG_FORCE = 18;
  localparam int TAG_LSB = 16;
  localparam int BIT_SID_CHK = 15;
  localparam int SID_LSB = 9;
  localparam int PART_LSB = 6;
  localparam int CHAN_LSB = 0;
  localparam logic [31:0] CFG_WMASK = 32'hbfff_feff;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Local CIP settings register fields
  // ----------------------------------------------------------------
  localparam int LOC_DBS_LSB = 19;
  localparam int LOC_FN_LSB = 17;
  localparam int LOC_QPS_LSB = 14;
  localparam int LOC_FMT_LSB = 8;
  localparam int LOC_FDF_LSB = 0;
  localparam logic [31:0] LOC_WMASK = 32'h07ff_ffff;
  localparam logic [31:0] LOC_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Status, clear and enable layout
  // ----------------------------------------------------------------
  localparam int STAT_W = 3;
  localparam int ST_CFG_FAIL = 0;
  localparam int ST_SID_FAIL = 1;
  localparam int ST_NODATA = 2;
  localparam logic [2:0] STAT_RST = 3'h0;

  // ----------------------------------------------------------------
  // Empty packet codes
  // ----------------------------------------------------------------
  localparam logic [7:0] NODATA_FDF = 8'hff;
  localparam logic [5:0] NODATA_FMT = 6'h3f;

  typedef enum logic [1:0] {
    IHC_IDLE  = 2'b00,
    IHC_CHECK = 2'b01,
    IHC_DATA  = 2'b10,
    IHC_SKIP  = 2'b11
  } ihc_state_t;

endpackage

// ==== verilog/ihc_chk_if.sv ====
// Purpose: Carries settings and one header from the top to the checker
// Assumes: Single clock domain
// Notes:   Results come back registered, one cycle after hdr_stb
interface ihc_chk_if;
  logic [31:0] cfg;
  logic [31:0] loc;
  logic hdr_stb;
  logic [1:0] hdr_tag;
  logic [5:0] hdr_sid;
  logic [1:0] hdr_fn;
  logic [2:0] hdr_qps;
  logic hdr_sph;
  logic [5:0] hdr_fmt;
  logic [7:0] hdr_fdf;
  logic [7:0] hdr_dbs;
  logic done;
  logic cfg_fail;
  logic sid_fail;
  logic nodata;
  logic eff_sph;
  logic [1:0] eff_tag;

  modport top (
    output cfg, loc, hdr_stb, hdr_tag, hdr_sid, hdr_fn, hdr_qps, hdr_sph,
    output hdr_fmt, hdr_fdf, hdr_dbs,
    input done, cfg_fail, sid_fail, nodata, eff_sph, eff_tag
  );
  modport chk (
    input cfg, loc, hdr_stb, hdr_tag, hdr_sid, hdr_fn, hdr_qps, hdr_sph,
    input hdr_fmt, hdr_fdf, hdr_dbs,
    output done, cfg_fail, sid_fail, nodata, eff_sph, eff_tag
  );
endinterface

// ==== verilog/ihc_hdr_check.sv ====
// Purpose: Compares one received header against the local settings
// Assumes: Header fields are stable in the hdr_stb cycle
// Notes:   All results are registered and valid with done
module ihc_hdr_check (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Settings and header
  ihc_chk_if.chk chk
);

  logic done_reg, done_next;
  logic cfg_fail_reg, cfg_fail_next;
  logic sid_fail_reg, sid_fail_next;
  logic nodata_reg, nodata_next;
  logic eff_sph_reg, eff_sph_next;
  logic [1:0] eff_tag_reg, eff_tag_next;

  // ----------------------------------------------------------------
  // Comparison
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] c;
    logic [31:0] l;
    logic miss;
    c = chk.cfg;
    l = chk.loc;
    miss = 1'b0;
    done_next = chk.hdr_stb;
    cfg_fail_next = cfg_fail_reg;
    sid_fail_next = sid_fail_reg;
    nodata_next = nodata_reg;
    eff_sph_next = eff_sph_reg;
    eff_tag_next = eff_tag_reg;
    if (chk.hdr_stb) begin
      if (c[ihc_pkg::BIT_FN_CHK] && chk.hdr_fn != l[ihc_pkg::LOC_FN_LSB +: 2]) begin // R1
        miss = 1'b1;
      end
      if (c[ihc_pkg::BIT_QPS_CHK] && chk.hdr_qps != l[ihc_pkg::LOC_QPS_LSB +: 3]) begin // R2
        miss = 1'b1;
      end
      if (c[ihc_pkg::BIT_SPH_CHK] && chk.hdr_sph != c[ihc_pkg::BIT_SPH_VAL]) begin // R3
        miss = 1'b1;
      end
      if (c[ihc_pkg::BIT_TAG_CHK] && chk.hdr_tag != c[ihc_pkg::TAG_LSB +: 2]) begin // R4
        miss = 1'b1;
      end
      if (c[ihc_pkg::BIT_FMT_CHK] && chk.hdr_fmt != l[ihc_pkg::LOC_FMT_LSB +: 6]) begin // R15
        miss = 1'b1;
      end
      if (c[ihc_pkg::BIT_FDF_CHK] && chk.hdr_fdf != l[ihc_pkg::LOC_FDF_LSB +: 8]) begin // R15
        miss = 1'b1;
      end
      if (c[ihc_pkg::BIT_DBS_CHK] && chk.hdr_dbs != l[ihc_pkg::LOC_DBS_LSB +: 8]) begin // R15
        miss = 1'b1;
      end
      cfg_fail_next = miss;
      sid_fail_next = c[ihc_pkg::BIT_SID_CHK] &&
                      (chk.hdr_sid != c[ihc_pkg::SID_LSB +: 6]); // R10
      if (c[ihc_pkg::BIT_NODATA_FDF]) begin
        nodata_next = (chk.hdr_fdf == ihc_pkg::NODATA_FDF); // R7
      end else begin
        nodata_next = (chk.hdr_fmt == ihc_pkg::NODATA_FMT); // R7
      end
      eff_sph_next = c[ihc_pkg::BIT_SPH_FORCE] ? c[ihc_pkg::BIT_SPH_VAL] : chk.hdr_sph; // R8
      eff_tag_next = c[ihc_pkg::BIT_TAG_FORCE] ? c[ihc_pkg::TAG_LSB +: 2] : chk.hdr_tag; // R9
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_reg <= 1'b0;
      cfg_fail_reg <= 1'b0;
      sid_fail_reg <= 1'b0;
      nodata_reg <= 1'b0;
      eff_sph_reg <= 1'b0;
      eff_tag_reg <= 2'h0;
    end else begin
      done_reg <= done_next;
      cfg_fail_reg <= cfg_fail_next;
      sid_fail_reg <= sid_fail_next;
      nodata_reg <= nodata_next;
      eff_sph_reg <= eff_sph_next;
      eff_tag_reg <= eff_tag_next;
    end
  end

  assign chk.done = done_reg;
  assign chk.cfg_fail = cfg_fail_reg;
  assign chk.sid_fail = sid_fail_reg;
  assign chk.nodata = nodata_reg;
  assign chk.eff_sph = eff_sph_reg;
  assign chk.eff_tag = eff_tag_reg;

endmodule

// ==== test/ihc_chk_assertions.sv ====
// Purpose: Port-level assertions for the receive header checker
// Assumes: One clock, asynchronous active-low reset
// Notes:   Shadows the configuration word from completed bus writes
module ihc_chk_assertions (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  // Register bus
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [ihc_pkg::ADDR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // Link and outputs
  input wire logic HDR_VALID_IN,
  input wire logic HDR_READY_OUT,
  input wire logic [5:0] HDR_CHAN_IN,
  input wire logic [1:0] HDR_TAG_IN,
  input wire logic HDR_SPH_IN,
  input wire logic [7:0] HDR_DBS_IN,
  input wire logic DQ_VALID_IN,
  input wire logic DQ_READY_OUT,
  input wire logic MF_WR_OUT,
  input wire logic [1:0] MF_PART_OUT,
  input wire logic RX_SPH_OUT,
  input wire logic [1:0] RX_TAG_OUT,
  input wire logic [8:0] RX_DB_SIZE_OUT,
  input wire logic IRQ_OUT
);
  logic [31:0] cfg_reg;
  logic skip_reg;
  logic wr_ack;
  logic clr_wr;
  logic hdr_take;
  logic hdr_acc;

  assign wr_ack = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT;
  assign clr_wr = wr_ack && (WB_ADR_IN == ihc_pkg::CLR_OFS || WB_ADR_IN == ihc_pkg::IEN_OFS);
  assign hdr_take = HDR_VALID_IN && HDR_READY_OUT;
  assign hdr_acc = hdr_take && cfg_reg[31] && HDR_CHAN_IN == cfg_reg[5:0];

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cfg_reg <= 32'h0000_0000;
      skip_reg <= 1'b0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (wr_ack && WB_ADR_IN == ihc_pkg::CFG_OFS && WB_SEL_IN[b]) begin
          cfg_reg[8*b +: 8] <= WB_DAT_IN[8*b +: 8] & ihc_pkg::CFG_WMASK[8*b +: 8];
        end
      end
      if (hdr_take) begin
        skip_reg <= !hdr_acc;
      end
    end
  end

  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);

  // Header beat, one check cycle, then data phase
  sequence check_then_data;
    ##1 (!HDR_READY_OUT && !DQ_READY_OUT) ##1 DQ_READY_OUT;
  endsequence

  hdr_walk_a: assert property (hdr_acc |-> check_then_data)
    else $error("header walk broken");
  ack_answer_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("bus ack missing");
  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("bus ack too long");
  cfg_read_a: assert property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == ihc_pkg::CFG_OFS |-> WB_DAT_OUT == cfg_reg)
    else $error("config readback wrong");
  tag_force_a: assert property (hdr_acc |-> ##3 RX_TAG_OUT == ($past(cfg_reg[18], 3) ? $past(cfg_reg[17:16], 3) : $past(HDR_TAG_IN, 3)))
    else $error("effective tag wrong");
  sph_force_a: assert property (hdr_acc |-> ##3 RX_SPH_OUT == ($past(cfg_reg[20], 3) ? $past(cfg_reg[19], 3) : $past(HDR_SPH_IN, 3)))
    else $error("effective sph wrong");
  part_sel_a: assert property (hdr_acc |-> ##3 MF_PART_OUT == $past(cfg_reg[7:6], 3))
    else $error("partition wrong");
  db_size_a: assert property (hdr_acc |-> ##3 RX_DB_SIZE_OUT == ($past(cfg_reg[22], 3) ? {$past(HDR_DBS_IN, 3), 1'b0} : {1'b0, $past(HDR_DBS_IN, 3)}))
    else $error("block size wrong");
  skip_write_a: assert property (MF_WR_OUT |-> !skip_reg)
    else $error("write from skipped packet");
  mf_cause_a: assert property (MF_WR_OUT |-> $past(DQ_VALID_IN && DQ_READY_OUT))
    else $error("write without data beat");
  irq_fall_a: assert property ($fell(IRQ_OUT) |-> clr_wr || $past(clr_wr))
    else $error("interrupt dropped by itself");
endmodule

bind isoch_rx_header_check ihc_chk_assertions u_chk (.*);

// ==== test/ihc_link_src.sv ====
// Purpose: Link receive path model feeding header and quadlet beats
// Assumes: Bench clock, one packet at a time
// Notes:   Released lines show the inverse of their last value
module ihc_link_src (
  // Clock
  input wire logic clk_in,
  // Header beat
  output logic hdr_valid_out,
  input wire logic hdr_ready_in,
  output logic [41:0] hdr_out,
  // Data beats
  output logic dq_valid_out,
  input wire logic dq_ready_in,
  output logic [31:0] dq_data_out,
  output logic dq_last_out
);
  initial begin
    hdr_valid_out = 1'b0;
    hdr_out = '0;
    dq_valid_out = 1'b0;
    dq_data_out = '0;
    dq_last_out = 1'b0;
  end

  task automatic send(input logic [41:0] h, input int n, input logic [31:0] base,
                      input logic slow);
    @(posedge clk_in);
    hdr_valid_out <= 1'b1;
    hdr_out <= h;
    do @(posedge clk_in); while (hdr_ready_in !== 1'b1);
    hdr_valid_out <= 1'b0;
    hdr_out <= ~h;
    for (int i = 0; i < n; i++) begin
      if (slow) begin
        dq_valid_out <= 1'b0;
        @(posedge clk_in);
      end
      dq_valid_out <= 1'b1;
      dq_data_out <= base + i;
      dq_last_out <= (i == n - 1);
      do @(posedge clk_in); while (dq_ready_in !== 1'b1);
    end
    dq_valid_out <= 1'b0;
    dq_data_out <= ~(base + n - 1);
    dq_last_out <= 1'b0;
  endtask
endmodule

// ==== test/isoch_rx_header_check_tb.sv ====
// Purpose: Self-checking bench for the receive header checker
// Assumes: Random packets from a seeded shift register
// Notes:   Expected status and quadlets come from a bench model
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, (e), (g)); end end
module isoch_rx_header_check_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, cyc, stb, we, ack, hvld, hrdy, dvld, drdy, dlast;
  logic mf_wr, mf_end, rx_sph, irq;
  logic [1:0] mf_part, rx_tag;
  logic [3:0] sel;
  logic [4:0] adr;
  logic [8:0] rx_size;
  logic [31:0] wdat, rdat, ddat, mf_dat, lfsr;
  logic [34:0] mf_exp;
  logic [41:0] hdr;
  logic [34:0] exp_q[$];
  logic [4:0] ro_adr[3] = '{5'h08, 5'h0c, 5'h14};
  int err_total, compares, cycles;

  isoch_rx_header_check dut (
    .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .HDR_VALID_IN(hvld), .HDR_READY_OUT(hrdy),
    .HDR_CHAN_IN(hdr[41:36]), .HDR_TAG_IN(hdr[35:34]), .HDR_SID_IN(hdr[33:28]),
    .HDR_FN_IN(hdr[27:26]), .HDR_QPS_IN(hdr[25:23]), .HDR_SPH_IN(hdr[22]),
    .HDR_FMT_IN(hdr[21:16]), .HDR_FDF_IN(hdr[15:8]), .HDR_DBS_IN(hdr[7:0]),
    .DQ_VALID_IN(dvld), .DQ_READY_OUT(drdy), .DQ_DATA_IN(ddat), .DQ_LAST_IN(dlast),
    .MF_WR_OUT(mf_wr), .MF_DATA_OUT(mf_dat), .MF_PART_OUT(mf_part),
    .MF_BLK_END_OUT(mf_end), .RX_SPH_OUT(rx_sph), .RX_TAG_OUT(rx_tag),
    .RX_DB_SIZE_OUT(rx_size), .IRQ_OUT(irq)
  );
  ihc_link_src src (
    .clk_in(clk), .hdr_valid_out(hvld), .hdr_ready_in(hrdy), .hdr_out(hdr),
    .dq_valid_out(dvld), .dq_ready_in(drdy), .dq_data_out(ddat), .dq_last_out(dlast)
  );

  // ----------------------------------------------------------------
  // Helpers and model
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic [2:0] exp_stat(input logic [31:0] c, l, input logic [41:0] h);
    logic [2:0] s;
    s = 3'h0;
    if (c[31] && h[41:36] == c[5:0]) begin
      s[0] = (c[26] && h[27:26] != l[18:17]) || (c[25] && h[25:23] != l[16:14])
        || (c[24] && h[22] != c[19]) || (c[23] && h[35:34] != c[17:16])
        || (c[29] && h[21:16] != l[13:8]) || (c[28] && h[15:8] != l[7:0])
        || (c[27] && h[7:0] != l[26:19]);
      s[1] = c[15] && h[33:28] != c[14:9];
      s[2] = c[21] ? h[15:8] == 8'hff : h[21:16] == 6'h3f;
    end
    return s;
  endfunction

  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic end_sim();
    $display("Comparisons %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      end_sim();
    end
    if (rst_n && mf_wr === 1'b1) begin
      mf_exp = (exp_q.size() != 0) ? exp_q.pop_front() : 35'h0;
      `CHK("mf quadlet", mf_exp, {mf_end, mf_part, mf_dat})
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q, c, l, r, base;
    logic [41:0] h;
    logic [2:0] es, ien;
    logic acc;
    int n, sz;
    {rst_n, cyc, stb, we, adr, wdat, err_total, compares, cycles} = '0;
    sel = 4'hf;
    lfsr = 32'h0000_001c;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      wb(1'b0, 5'(4 * a), 32'h0, q);
      `CHK("reset value", 32'h0, q)
    end
    foreach (ro_adr[i]) begin
      wb(1'b1, ro_adr[i], 32'hffff_ffff, q);
      wb(1'b0, ro_adr[i], 32'h0, q);
      `CHK("read only zero", 32'h0, q)
    end
    for (int k = 0; k < 60; k++) begin
      r = rnd();
      c = rnd();
      l = rnd();
      h[31:0] = rnd();
      q = rnd();
      h[41:32] = q[9:0];
      c[31] = r[2:0] != 3'h0;
      h[41:36] = (r[4:3] != 2'h0) ? c[5:0] : ~c[5:0];
      h[7:0] = {6'h00, r[6:5]};
      if (r[8:7] == 2'h0) h[21:16] = 6'h3f;
      if (r[10:9] == 2'h0) h[15:8] = 8'hff;
      if (r[11]) l[18:17] = h[27:26];
      if (r[12]) l[16:14] = h[25:23];
      if (r[13]) c[19] = h[22];
      if (r[14]) c[17:16] = h[35:34];
      if (r[15]) l[13:8] = h[21:16];
      if (r[16]) l[7:0] = h[15:8];
      if (r[17]) l[26:19] = h[7:0];
      if (r[18]) c[14:9] = h[33:28];
      if (c[22]) begin
        l[26:19] = h[7:0];
        l[7:0] = h[15:8];
      end
      ien = r[21:19];
      n = 1 + r[24:22];
      base = rnd();
      wb(1'b1, ihc_pkg::CFG_OFS, c, q);
      wb(1'b1, ihc_pkg::LOC_OFS, l, q);
      wb(1'b1, ihc_pkg::IEN_OFS, {29'h0, ien}, q);
      wb(1'b0, ihc_pkg::CFG_OFS, 32'h0, q);
      `CHK("cfg readback", c & ihc_pkg::CFG_WMASK, q)
      c = c & ihc_pkg::CFG_WMASK;
      l = l & ihc_pkg::LOC_WMASK;
      es = exp_stat(c, l, h);
      sz = c[22] ? 2 * h[7:0] : h[7:0];
      acc = c[31] && h[41:36] == c[5:0] && !es[2];
      for (int j = 0; j < n && acc; j++) begin
        exp_q.push_back({sz != 0 && (j + 1) % sz == 0, c[7:6], 32'(base + j)});
      end
      src.send(h, n, base, r[25]);
      repeat (2) @(posedge clk);
      if (acc) begin
        `CHK("rx tag", c[18] ? c[17:16] : h[35:34], rx_tag)
        `CHK("rx sph", c[20] ? c[19] : h[22], rx_sph)
        `CHK("block size", 9'(sz), rx_size)
      end
      wb(1'b0, ihc_pkg::STAT_OFS, 32'h0, q);
      `CHK("status", {29'h0, es}, q)
      `CHK("irq", |(es & ien), irq)
      wb(1'b1, ihc_pkg::CLR_OFS, 32'h0000_0007, q);
      wb(1'b0, ihc_pkg::STAT_OFS, 32'h0, q);
      `CHK("status cleared", 32'h0, q)
      `CHK("quadlets left", 0, exp_q.size())
    end
    end_sim();
  end
endmodule
